// >>> core/adcc_top.v
/*
  Converter control block: registers, start and stop control, sleep handling,
  special trigger, completion flag and interrupt request.
  Assumes a same-clock register port and same-clock sleep and trigger levels;
  comparator and RC oscillator come from outside and are synchronised here.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
// How it works
// RULE_01 - done flag sets at every completion, enable or not
// RULE_02 - software clears the done flag; hardware never does
// RULE_03 - interrupt request is done flag and interrupt enable together
// RULE_04 - sleep conversion only on RC clock; completion with enable wakes
// RULE_05 - enable powers converter; writing go starts conversion
// RULE_06 - software should not set go in the enabling write
// RULE_07 - completion clears go, sets flag, loads result
// RULE_08 - clearing go mid-run loads partial result, rest filled by last bit
// RULE_09 - reset returns all registers, converter off, conversion ended
// RULE_10 - RC clock delays start by one instruction cycle
// RULE_11 - sleep, RC, no interrupt: power down after finish, enable reads set
// RULE_12 - sleep with other clock aborts and powers down, enable reads set
// RULE_13 - special trigger sets go and clears the timer counter
// RULE_14 - trigger user must meet acquisition and clock timing
// RULE_15 - software waits acquisition time before setting go
// RULE_16 - channel codes map to inputs 0-4, 8-13, fixed reference
// RULE_17 - go reads one while converting, zero otherwise
// RULE_18 - enable clear disables converter, no operating current
// RULE_19 - clock field picks divide 2,8,32,4,16,64 or RC
// RULE_20 - reference field picks supply, external pin, fixed reference
// RULE_21 - result register is software read/write, 8 bits
// RULE_22 - conversion takes ten bit periods
// RULE_23 - start while disabled does nothing
// RULE_24 - bits resolve top down, one per bit period
`timescale 1ns/1ps
module adcc_top
(
  // clock and reset
  input  wire       I_REF_CLK,
  input  wire       I_SYS_RST,
  // register port
  input  wire [3:0] I_ADDR,
  input  wire [7:0] I_WR_DATA,
  input  wire       I_WR,
  input  wire       I_RD,
  output reg  [7:0] O_RD_DATA,
  // system events
  input  wire       I_SLEEP,
  input  wire       I_SPECIAL_TRIG,
  output reg        O_TIMER_CLEAR,
  output wire       O_IRQ,
  output wire       O_WAKE,
  // analog side
  input  wire       I_RC_OSC,
  input  wire       I_CMP_HIGH,
  output wire       O_CONV_POWER,
  output wire       O_SAMPLE,
  output wire [7:0] O_TRIAL_CODE,
  output wire [3:0] O_CHANNEL,
  output wire       O_CHANNEL_VALID,
  output wire       O_CHANNEL_FIXED_REF,
  output wire       O_REF_EXT,
  output wire       O_REF_FIXED
);

  `include "adcc_consts.vh"

  // ==========================================================
  // states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  localparam [31:0] INSTR_CYC_W = `ADCC_INSTR_CYC;
  localparam [2:0]  INSTR_CYC   = INSTR_CYC_W[2:0];

  // ==========================================================
  // reset images
  localparam [7:0] RST_CTL0  = `ADCC_RST_CTL_ZERO;
  localparam [7:0] RST_CTL1  = `ADCC_RST_CTL_ONE;
  localparam [7:0] RST_FLAGS = `ADCC_RST_FLAGS;

  // ==========================================================
  // helpers
  function is_rc;
    input [2:0] sel;
    begin
      is_rc = (sel[1:0] == 2'h3); // see RULE_19
    end
  endfunction

  function chan_ok;
    input [3:0] c;
    begin
      chan_ok = (c <= `ADCC_CHS_MAX_LOW)
             || ((c >= `ADCC_CHS_MIN_HIGH) && (c <= `ADCC_CHS_MAX_HIGH))
             || (c == `ADCC_CHS_FIXED_REF);
    end
  endfunction

  function reg_hit;
    input       strobe;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      reg_hit = strobe && (addr == ofs);
    end
  endfunction

  // ==========================================================
  // registers
  reg  [3:0] channel;
  reg        converter_enable;
  reg  [2:0] clk_sel;
  reg  [1:0] ref_sel;
  reg  [7:0] result;
  reg        done_flag;
  reg        irq_enable;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [2:0] wait_cnt;
  reg        sleep_off;
  reg        keep_partial;
  reg        rc_s1;
  reg        rc_s2;
  reg        rc_s3;
  reg        cmp_s1;
  reg        cmp_s2;

  wire       tad_tick;
  wire       sar_done;
  wire       sar_aborted;
  wire [7:0] sar_result;

  // ==========================================================
  // decode
  wire       wr_ctl0  = reg_hit(I_WR, I_ADDR, `ADCC_OFS_CTL_ZERO);
  wire       wr_ctl1  = reg_hit(I_WR, I_ADDR, `ADCC_OFS_CTL_ONE);
  wire       wr_res   = reg_hit(I_WR, I_ADDR, `ADCC_OFS_RESULT);
  wire       wr_flags = reg_hit(I_WR, I_ADDR, `ADCC_OFS_FLAGS);
  wire       busy     = (state != ST_IDLE);
  wire       rc_sel   = is_rc(clk_sel);
  wire       powered  = converter_enable && !sleep_off;

  // start needs the enable bit; a go with enable clear is dropped
  wire       sw_start = wr_ctl0 && I_WR_DATA[`ADCC_BIT_GO]
                     && I_WR_DATA[`ADCC_BIT_ENABLE]; // see RULE_05 see RULE_23
  wire       hw_start = I_SPECIAL_TRIG && converter_enable; // see RULE_13 see RULE_23
  wire       start    = (sw_start || hw_start) && !busy && !sleep_off;
  wire       sw_abort = wr_ctl0 && !I_WR_DATA[`ADCC_BIT_GO]; // see RULE_08
  // leaving enable off mid-run or sleeping on a divided clock ends the run
  wire       off_abort = (wr_ctl0 && !I_WR_DATA[`ADCC_BIT_ENABLE])
                      || (I_SLEEP && !rc_sel); // see RULE_12 see RULE_18
  wire       stop     = busy && (sw_abort || off_abort);
  // engine strobes
  wire       tad_run   = (state == ST_CONV);
  wire       sar_start = (next_state == ST_CONV) && (state != ST_CONV);
  wire       sar_abort = tad_run && stop;

  // ==========================================================
  // synchronisers
  always @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      rc_s1  <= 1'b0;
      rc_s2  <= 1'b0;
      rc_s3  <= 1'b0;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end
    else
    begin
      rc_s1  <= I_RC_OSC;
      rc_s2  <= rc_s1;
      rc_s3  <= rc_s2;
      cmp_s1 <= I_CMP_HIGH;
      cmp_s2 <= cmp_s1;
    end
  end

  // ==========================================================
  // control state machine
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (start)
          next_state = rc_sel ? ST_WAIT : ST_CONV; // see RULE_10
      end
      ST_WAIT:
      begin
        if (stop)
          next_state = ST_IDLE;
        else if (wait_cnt == INSTR_CYC - 3'h1)
          next_state = ST_CONV;
      end
      ST_CONV:
      begin
        if (stop || sar_done)
          next_state = ST_IDLE; // see RULE_07 see RULE_17
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state        <= ST_IDLE; // see RULE_09
      wait_cnt     <= 3'h0;
      keep_partial <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      wait_cnt     <= (state == ST_WAIT) ? wait_cnt + 3'h1 : 3'h0;
      // only a software go clear keeps the partial code
      keep_partial <= (state == ST_CONV) && sw_abort && !off_abort;
    end
  end

  // ==========================================================
  // sleep power control
  always @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      sleep_off <= 1'b0;
    end
    else
    begin
      if (!I_SLEEP)
        sleep_off <= 1'b0;
      else if (!rc_sel)
        sleep_off <= 1'b1; // see RULE_12
      else if (sar_done && !irq_enable)
        sleep_off <= 1'b1; // see RULE_11
    end
  end

  // ==========================================================
  // software registers
  always @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      channel          <= RST_CTL0[`ADCC_CHS_MSB:`ADCC_CHS_LSB];
      converter_enable <= RST_CTL0[`ADCC_BIT_ENABLE]; // see RULE_09
      clk_sel          <= RST_CTL1[`ADCC_CS_MSB:`ADCC_CS_LSB];
      ref_sel          <= RST_CTL1[`ADCC_REF_MSB:`ADCC_REF_LSB];
      result           <= `ADCC_RST_RESULT;
      done_flag        <= RST_FLAGS[`ADCC_BIT_DONE_FLAG];
      irq_enable       <= RST_FLAGS[`ADCC_BIT_IRQ_EN];
      O_TIMER_CLEAR    <= 1'b0;
    end
    else
    begin
      O_TIMER_CLEAR <= I_SPECIAL_TRIG; // see RULE_13
      if (wr_ctl0)
      begin
        channel          <= I_WR_DATA[`ADCC_CHS_MSB:`ADCC_CHS_LSB];
        converter_enable <= I_WR_DATA[`ADCC_BIT_ENABLE];
      end
      if (wr_ctl1)
      begin
        clk_sel <= I_WR_DATA[`ADCC_CS_MSB:`ADCC_CS_LSB];
        ref_sel <= I_WR_DATA[`ADCC_REF_MSB:`ADCC_REF_LSB];
      end
      // hardware load wins over a same-cycle software write
      if (sar_done || (sar_aborted && keep_partial))
        result <= sar_result; // see RULE_07 see RULE_08
      else if (wr_res)
        result <= I_WR_DATA; // see RULE_21
      if (wr_flags)
        irq_enable <= I_WR_DATA[`ADCC_BIT_IRQ_EN];
      // completion beats a same-cycle clear
      if (sar_done)
        done_flag <= 1'b1; // see RULE_01
      else if (wr_flags)
        done_flag <= I_WR_DATA[`ADCC_BIT_DONE_FLAG]; // see RULE_02
    end
  end

  // ==========================================================
  // read port
  always @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      O_RD_DATA <= 8'h00;
    else if (I_RD)
    begin
      case (I_ADDR)
        `ADCC_OFS_CTL_ZERO: O_RD_DATA <= {2'h0, channel, busy, converter_enable}; // see RULE_17
        `ADCC_OFS_CTL_ONE:  O_RD_DATA <= {1'b0, clk_sel, 2'h0, ref_sel};
        `ADCC_OFS_RESULT:   O_RD_DATA <= result;
        `ADCC_OFS_FLAGS:    O_RD_DATA <= {6'h00, irq_enable, done_flag};
        default:            O_RD_DATA <= 8'h00;
      endcase
    end
    else
      O_RD_DATA <= 8'h00;
  end

  // ==========================================================
  // conversion engine
  adcc_tad_gen u_tad
  (
    .i_clk     (I_REF_CLK),
    .i_rst     (I_SYS_RST),
    .i_run     (tad_run),
    .i_sel     (clk_sel),
    .i_rc_edge (rc_s2 & ~rc_s3),
    .o_tick    (tad_tick)
  );

  // comparator is two cycles late after sync; slow divides give it settle room
  // divide by 2 decides on a stale compare, so its results are not exact
  adcc_sar u_sar
  (
    .i_clk      (I_REF_CLK),
    .i_rst      (I_SYS_RST),
    .i_start    (sar_start),
    .i_abort    (sar_abort),
    .i_tick     (tad_tick),
    .i_cmp_high (cmp_s2),
    .o_done     (sar_done),
    .o_aborted  (sar_aborted),
    .o_result   (sar_result),
    .o_trial    (O_TRIAL_CODE)
  );

  // ==========================================================
  // outputs
  assign O_IRQ               = done_flag && irq_enable; // see RULE_03
  assign O_WAKE              = I_SLEEP && done_flag && irq_enable && rc_sel; // see RULE_04
  assign O_CONV_POWER        = powered; // see RULE_18 see RULE_11
  assign O_SAMPLE            = powered && (state != ST_CONV);
  assign O_CHANNEL           = channel;
  assign O_CHANNEL_VALID     = chan_ok(channel); // see RULE_16
  assign O_CHANNEL_FIXED_REF = (channel == `ADCC_CHS_FIXED_REF);
  assign O_REF_EXT           = (ref_sel == `ADCC_REF_EXT); // see RULE_20
  assign O_REF_FIXED         = (ref_sel == `ADCC_REF_FIXED);

endmodule

// >>> core/adcc_consts.vh
/*
  Constants of the converter control block: register offsets, field positions,
  reset values, codes and timing counts.
  Assumes inclusion by bare name from the core design files.
*/
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH

// ==========================================================
// register offsets
`define ADCC_OFS_CTL_ZERO    4'h0
`define ADCC_OFS_CTL_ONE     4'h1
`define ADCC_OFS_RESULT      4'h2
`define ADCC_OFS_FLAGS       4'h3

// ==========================================================
// field positions
`define ADCC_BIT_ENABLE      0
`define ADCC_BIT_GO          1
`define ADCC_CHS_LSB         2
`define ADCC_CHS_MSB         5
`define ADCC_REF_LSB         0
`define ADCC_REF_MSB         1
`define ADCC_CS_LSB          4
`define ADCC_CS_MSB          6
`define ADCC_BIT_DONE_FLAG   0
`define ADCC_BIT_IRQ_EN      1

// ==========================================================
// reset values
`define ADCC_RST_CTL_ZERO    8'h00
`define ADCC_RST_CTL_ONE     8'h00
`define ADCC_RST_RESULT      8'h00
`define ADCC_RST_FLAGS       8'h00

// ==========================================================
// codes
`define ADCC_CHS_FIXED_REF   4'hF
`define ADCC_CHS_MAX_LOW     4'h4
`define ADCC_CHS_MIN_HIGH    4'h8
`define ADCC_CHS_MAX_HIGH    4'hD
`define ADCC_REF_EXT         2'h2
`define ADCC_REF_FIXED       2'h3
`define ADCC_SAR_FIRST_BIT   8'h80

// ==========================================================
// timing
`define ADCC_TAD_PER_CONV    4'hA
`define ADCC_CLK_NS          40
`define ADCC_OSC_PER_INSTR   4
`define ADCC_INSTR_NS        (`ADCC_OSC_PER_INSTR * `ADCC_CLK_NS)
`define ADCC_INSTR_CYC       ((`ADCC_INSTR_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

`endif

// >>> core/adcc_tad_gen.v
/*
  Bit conversion period tick generator: divides the system clock or passes the
  dedicated RC oscillator edge.
  Assumes rc_edge is already synchronised and one cycle long.
*/
`timescale 1ns/1ps
module adcc_tad_gen
(
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // control
  input  wire       i_run,
  input  wire [2:0] i_sel,
  input  wire       i_rc_edge,
  // tick out
  output reg        o_tick
);

  // ==========================================================
  // divider
  reg  [5:0] cnt;
  reg  [5:0] last;

  always @*
  begin
    case (i_sel)
      3'h0:    last = 6'h01;
      3'h4:    last = 6'h03;
      3'h1:    last = 6'h07;
      3'h5:    last = 6'h0F;
      3'h2:    last = 6'h1F;
      3'h6:    last = 6'h3F;
      default: last = 6'h00;
    endcase
  end

  // counter restarts with every run so the first period is whole
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt    <= 6'h00;
      o_tick <= 1'b0;
    end
    else if (!i_run)
    begin
      cnt    <= 6'h00;
      o_tick <= 1'b0;
    end
    else if (i_sel[1:0] == 2'h3)
    begin
      cnt    <= 6'h00;
      o_tick <= i_rc_edge;
    end
    else if (cnt == last)
    begin
      cnt    <= 6'h00;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt    <= cnt + 6'h01;
      o_tick <= 1'b0;
    end
  end

endmodule

// >>> core/adcc_sar.v
/*
  Successive approximation sequencer: ten bit periods per conversion, bits
  resolved from the top down, partial result on abort.
  Assumes a synchronised comparator level and one-cycle tick, start and abort.
*/
`timescale 1ns/1ps
module adcc_sar
(
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // control
  input  wire       i_start,
  input  wire       i_abort,
  input  wire       i_tick,
  input  wire       i_cmp_high,
  // status and data
  output reg        o_done,
  output reg        o_aborted,
  output reg  [7:0] o_result,
  output reg  [7:0] o_trial
);

  `include "adcc_consts.vh"

  reg  [3:0] tad;
  reg  [7:0] mask;
  reg        run;

  // ==========================================================
  // fill unresolved bits with the last resolved one
  function [7:0] fill_partial;
    input [7:0] code;
    input [7:0] m;
    reg   [8:0] lower;
    reg         lastbit;
    begin
      lower        = {m, 1'b0} - 9'h001;
      lastbit      = |({1'b0, code} & {m, 1'b0});
      // all bits resolved: nothing left to fill
      if (m == 8'h00)
        fill_partial = code;
      else
        fill_partial = (code & ~lower[7:0]) | (lastbit ? lower[7:0] : 8'h00);
    end
  endfunction

  // ==========================================================
  // sequence
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tad       <= 4'h0;
      mask      <= 8'h00;
      run       <= 1'b0;
      o_done    <= 1'b0;
      o_aborted <= 1'b0;
      o_result  <= 8'h00;
      o_trial   <= 8'h00;
    end
    else
    begin
      o_done    <= 1'b0;
      o_aborted <= 1'b0;
      if (i_start)
      begin
        tad     <= 4'h0;
        mask    <= `ADCC_SAR_FIRST_BIT;
        o_trial <= 8'h00;
        run     <= 1'b1;
      end
      else if (run && i_abort)
      begin
        run       <= 1'b0;
        o_aborted <= 1'b1;
        o_result  <= fill_partial(o_trial, mask); // see RULE_08
      end
      else if (run && i_tick)
      begin
        tad <= tad + 4'h1;
        if (tad == 4'h0)
          o_trial <= mask;
        else if (tad == `ADCC_TAD_PER_CONV - 4'h1)
        begin
          run      <= 1'b0;
          o_done   <= 1'b1;
          o_result <= o_trial; // see RULE_22
        end
        else if (mask != 8'h00)
        begin
          // top bit first, one per period; see RULE_24
          o_trial <= (i_cmp_high ? o_trial : (o_trial & ~mask)) | (mask >> 1);
          mask    <= mask >> 1;
        end
      end
    end
  end

endmodule

// >>> tb/adcc_analog_model.sv
/*
  Analog side model: comparator against a bench level, and the RC oscillator.
  Assumes the bench sets the level and starts the oscillator.
*/
`timescale 1ns/1ps
module adcc_analog_model
(
  // clock and converter side
  input  wire       i_clk,
  input  wire       i_power,
  input  wire [7:0] i_trial,
  // bench controls
  input  wire [7:0] i_level,
  input  wire       i_rc_run,
  // answers
  output wire       o_cmp_high,
  output reg        o_rc_osc
);
  // ====================
  // comparator
  reg toggle;
  initial
  begin
    toggle = 1'b0;
    o_rc_osc = 1'b0;
  end
  always @(posedge i_clk) toggle <= ~toggle;
  // unpowered: moving pattern, never a stale level
  assign o_cmp_high = i_power ? (i_level >= i_trial) : toggle;
  // ====================
  // rc oscillator, still unless asked to run
  always #100 o_rc_osc = i_rc_run ? ~o_rc_osc : 1'b0;
endmodule

// >>> tb/adcc_top_asserts.sv
/*
  Port checker for the converter block.
  Assumes one clock and an active high asynchronous reset.
*/
`timescale 1ns/1ps
module adcc_top_checker
(
  input wire       I_REF_CLK,
  input wire       I_SYS_RST,
  input wire [3:0] I_ADDR,
  input wire [7:0] I_WR_DATA,
  input wire       I_WR,
  input wire       I_RD,
  input wire [7:0] O_RD_DATA,
  input wire       I_SLEEP,
  input wire       I_SPECIAL_TRIG,
  input wire       O_TIMER_CLEAR,
  input wire       O_IRQ,
  input wire       O_WAKE,
  input wire       I_RC_OSC,
  input wire       I_CMP_HIGH,
  input wire       O_CONV_POWER,
  input wire       O_SAMPLE,
  input wire [7:0] O_TRIAL_CODE,
  input wire [3:0] O_CHANNEL,
  input wire       O_CHANNEL_VALID,
  input wire       O_CHANNEL_FIXED_REF,
  input wire       O_REF_EXT,
  input wire       O_REF_FIXED
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_rd_idle;
    !$past(I_RD) |-> O_RD_DATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_flags_rd;
    $past(I_RD) && $past(I_ADDR) == 4'h3 |-> O_RD_DATA[7:2] == 6'h00
      && (O_RD_DATA[1:0] == 2'b11) == $past(O_IRQ);
  endproperty
  a_flags_rd: assert property (p_flags_rd) else $error("irq disagrees with flags");
  property p_trig;
    I_SPECIAL_TRIG |=> O_TIMER_CLEAR;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger without timer clear");
  property p_clr_cause;
    O_TIMER_CLEAR |-> $past(I_SPECIAL_TRIG);
  endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("stray timer clear");
  property p_chan_ok;
    O_CHANNEL_VALID == (O_CHANNEL <= 4'h4 || O_CHANNEL == 4'hF
      || (O_CHANNEL >= 4'h8 && O_CHANNEL <= 4'hD));
  endproperty
  a_chan_ok: assert property (p_chan_ok) else $error("channel valid wrong");
  property p_chan_ref;
    O_CHANNEL_FIXED_REF == (O_CHANNEL == 4'hF);
  endproperty
  a_chan_ref: assert property (p_chan_ref) else $error("fixed ref channel wrong");
  property p_ref;
    !(O_REF_EXT && O_REF_FIXED);
  endproperty
  a_ref: assert property (p_ref) else $error("two references at once");
  property p_wake;
    O_WAKE |-> I_SLEEP && O_IRQ;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_irq_fall;
    $fell(O_IRQ) |-> $past(I_WR);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
  property p_pwr_samp;
    !O_CONV_POWER |-> !O_SAMPLE;
  endproperty
  a_pwr_samp: assert property (p_pwr_samp) else $error("tracking while off");
  property p_rst_off;
    $fell(I_SYS_RST) |-> !O_CONV_POWER && !O_IRQ && !O_TIMER_CLEAR;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("not off after reset");
endmodule
bind adcc_top adcc_top_checker u_chk
(
  .I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WR_DATA(I_WR_DATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RD_DATA(O_RD_DATA), .I_SLEEP(I_SLEEP),
  .I_SPECIAL_TRIG(I_SPECIAL_TRIG), .O_TIMER_CLEAR(O_TIMER_CLEAR), .O_IRQ(O_IRQ),
  .O_WAKE(O_WAKE), .I_RC_OSC(I_RC_OSC), .I_CMP_HIGH(I_CMP_HIGH), .O_SAMPLE(O_SAMPLE),
  .O_CONV_POWER(O_CONV_POWER), .O_TRIAL_CODE(O_TRIAL_CODE), .O_CHANNEL(O_CHANNEL),
  .O_CHANNEL_VALID(O_CHANNEL_VALID), .O_CHANNEL_FIXED_REF(O_CHANNEL_FIXED_REF),
  .O_REF_EXT(O_REF_EXT), .O_REF_FIXED(O_REF_FIXED)
);

// >>> tb/adcc_top_tb.sv
/*
  Self-checking bench for the converter block.
  Assumes the analog model on the far side and one 25 MHz clock.
*/
`timescale 1ns/1ps
module adcc_top_tb;
  reg        clk, rst, wr_s, rd_s, sleep, trig, rc_run;
  reg  [3:0] addr;
  reg  [7:0] wdata, lvl, d;
  wire [7:0] rd_data, trial;
  wire [3:0] chan;
  wire       tclr, irq, wake, rc_osc, cmp, pwr, samp, ch_ok, ch_ref, r_ext, r_fix;
  integer    err_total, compares, k, c, cyc, dv;
  adcc_top dut
  (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WR_DATA(wdata), .I_WR(wr_s),
    .I_RD(rd_s), .O_RD_DATA(rd_data), .I_SLEEP(sleep), .I_SPECIAL_TRIG(trig),
    .O_TIMER_CLEAR(tclr), .O_IRQ(irq), .O_WAKE(wake), .I_RC_OSC(rc_osc), .I_CMP_HIGH(cmp),
    .O_CONV_POWER(pwr), .O_SAMPLE(samp), .O_TRIAL_CODE(trial), .O_CHANNEL(chan),
    .O_CHANNEL_VALID(ch_ok), .O_CHANNEL_FIXED_REF(ch_ref), .O_REF_EXT(r_ext),
    .O_REF_FIXED(r_fix)
  );
  adcc_analog_model ana
  (
    .i_clk(clk), .i_power(pwr), .i_trial(trial), .i_level(lvl), .i_rc_run(rc_run),
    .o_cmp_high(cmp), .o_rc_osc(rc_osc)
  );
  always #20 clk = ~clk;
  // ====================
  // tasks
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        err_total = err_total + 1;
        $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("mismatches %0d of %0d compares", err_total, compares);
      if (err_total == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge clk);
      {addr, wdata, wr_s} <= {a, v, 1'b1};
      @(posedge clk);
      wr_s <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      {addr, rd_s} <= {a, 1'b1};
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      d = rd_data;
    end
  endtask
  // polls go; cyc ends as cycles since the start write
  task wait_idle(input integer lim);
    begin
      cyc = 2;
      rd(4'h0);
      while (d[1] !== 1'b0)
      begin
        rd(4'h0);
        cyc = cyc + 2;
        if (cyc > lim)
        begin
          chk(8'hEE, 8'h00);
          final_report;
        end
      end
    end
  endtask
  // enable first, settle, then go: never go in the enabling write
  task start(input [7:0] c1, input [7:0] lv);
    begin
      lvl <= lv;
      wr(4'h1, c1);
      wr(4'h0, 8'h01);
      repeat (4) @(posedge clk);
      wr(4'h0, 8'h03);
    end
  endtask
  // ====================
  // sequence
  initial
  begin
    {clk, rst, wr_s, rd_s, sleep, trig, rc_run} = 7'h20;
    {addr, wdata, lvl, err_total, compares} = 84'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 4; k = k + 1)
    begin
      rd(k[3:0] == 4'h2 ? 4'h7 : k[3:0]);
      chk(d, 8'h00);
    end
    wr(4'h7, 8'hFF);
    rd(4'h7);
    chk(d, 8'h00);
    wr(4'h2, 8'hA5);
    rd(4'h2);
    chk(d, 8'hA5);
    for (k = 0; k < 16; k = k + 1)
    begin
      wr(4'h0, {2'b11, k[3:0], 2'b00});
      wr(4'h1, {6'h3F, k[1:0]});
      rd(4'h1);
      chk(d, {6'h00, k[1:0]} | 8'h70);
      chk({4'h0, chan}, {4'h0, k[3:0]});
      chk({6'h00, r_ext, r_fix}, {6'h00, k[1:0] == 2'b10, k[1:0] == 2'b11});
    end
    for (k = 0; k < 6; k = k + 1)
    begin
      c = (k < 3) ? k : k + 1;
      dv = (c < 4) ? (2 << (2 * c)) : (4 << (2 * (c - 4)));
      // divide by 2 is below the shortest bit period: only full scale stays exact
      start({1'b0, c[2:0], 4'h0}, (c == 0) ? 8'hFF : 8'h1B + k[7:0] * 8'h2D);
      wait_idle(800);
      chk({7'h00, cyc >= 10 * dv && cyc <= 10 * dv + 8}, 8'h01);
      rd(4'h2);
      chk(d, lvl);
      rd(4'h3);
      chk(d, 8'h01);
      chk({7'h00, irq}, 8'h00);
      rd(4'h3);
      chk(d, 8'h01);
      wr(4'h3, 8'h00);
    end
    start(8'h60, 8'hF0);
    repeat (220) @(posedge clk);
    wr(4'h0, 8'h01);
    rd(4'h2);
    chk(d, 8'hFF);
    rd(4'h3);
    chk(d, 8'h00);
    rd(4'h0);
    chk(d, 8'h01);
    wr(4'h2, 8'h3C);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h02);
    repeat (30) @(posedge clk);
    rd(4'h0);
    chk(d, 8'h00);
    rd(4'h2);
    chk({d[7:1], pwr}, 8'h3C);
    @(posedge clk);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h01);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    #1;
    chk({7'h00, tclr}, 8'h01);
    rd(4'h0);
    chk(d, 8'h03);
    wait_idle(100);
    wr(4'h3, 8'h02);
    rc_run <= 1'b1;
    start(8'h30, 8'h96);
    sleep <= 1'b1;
    wait_idle(300);
    chk({6'h00, wake, irq}, 8'h03);
    rd(4'h2);
    chk(d, 8'h96);
    wr(4'h3, 8'h02);
    sleep <= 1'b0;
    #1;
    chk({7'h00, irq}, 8'h00);
    wr(4'h3, 8'h00);
    start(8'h70, 8'h3C);
    sleep <= 1'b1;
    wait_idle(300);
    chk({6'h00, pwr, wake}, 8'h00);
    rd(4'h0);
    chk(d, 8'h01);
    rd(4'h2);
    chk(d, 8'h3C);
    @(posedge clk);
    {sleep, rc_run} <= 2'b00;
    repeat (3) @(posedge clk);
    chk({7'h00, pwr}, 8'h01);
    wr(4'h3, 8'h00);
    start(8'h60, 8'h55);
    repeat (50) @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h00, pwr}, 8'h00);
    rd(4'h0);
    chk(d, 8'h01);
    rd(4'h3);
    chk(d, 8'h00);
    @(posedge clk);
    sleep <= 1'b0;
    start(8'h60, 8'h11);
    repeat (20) @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0);
    chk({d[7:1], pwr}, 8'h00);
    final_report;
  end
endmodule
